// ==== shared/rps_consts.svh ====
`ifndef RPS_CONSTS_SVH
`define RPS_CONSTS_SVH

// Register geometry: each mapping register is eight bits, five of them a selection field.
`define RPS_REG_W 8
`define RPS_FIELD_W 5
`define RPS_FIELD_LSB 0
`define RPS_LOCK_BIT 0

// Register indices; the APB byte address is four times the index.
`define RPS_IDX_PIN0_OUT 12'hEC6
`define RPS_IDX_PIN1_OUT 12'hEC7
`define RPS_IDX_PIN2_OUT 12'hEC8
`define RPS_IDX_CAPTURE1 12'hEED
`define RPS_IDX_CAPTURE2 12'hEEE
`define RPS_IDX_TIMER_A_GATE 12'hEF2
`define RPS_IDX_TIMER_C_GATE 12'hEF3
`define RPS_IDX_SERIAL2_RX 12'hEF6
`define RPS_IDX_SERIAL2_CLK 12'hEF7
`define RPS_IDX_SPI2_DATA 12'hEFB
`define RPS_IDX_SPI2_CLK 12'hEFC
`define RPS_IDX_SPI2_SEL 12'hEFD
`define RPS_IDX_PWM_FAULT 12'hEFE
`define RPS_IDX_LOCK_CTRL 12'hEFF
`define RPS_IDX_UNLOCK 12'hF00

// Internal slot numbers of the decoded registers.
`define RPS_NUM_SEL 13
`define RPS_NUM_OUT 3
`define RPS_SLOT_PIN0 4'h0
`define RPS_SLOT_PIN1 4'h1
`define RPS_SLOT_PIN2 4'h2
`define RPS_SLOT_CAPTURE1 4'h3
`define RPS_SLOT_CAPTURE2 4'h4
`define RPS_SLOT_TIMER_A 4'h5
`define RPS_SLOT_TIMER_C 4'h6
`define RPS_SLOT_SER_RX 4'h7
`define RPS_SLOT_SER_CLK 4'h8
`define RPS_SLOT_SPI_DATA 4'h9
`define RPS_SLOT_SPI_CLK 4'hA
`define RPS_SLOT_SPI_SEL 4'hB
`define RPS_SLOT_FAULT 4'hC
`define RPS_SLOT_LOCK 4'hD
`define RPS_SLOT_UNLOCK 4'hE
`define RPS_SLOT_NONE 4'hF

// Reset values.
`define RPS_IN_RESET 5'h1F
`define RPS_OUT_RESET 5'h00
`define RPS_LOCK_RESET 1'b0

// Unlock key bytes written in this order just before a lock change.
`define RPS_UNLOCK_KEY1 8'h55
`define RPS_UNLOCK_KEY2 8'hAA

`endif

// ==== shared/rps_pkg.sv ====
`include "rps_consts.svh"

package rps_pkg;

  typedef logic [3:0] rps_slot_t;
  typedef logic [`RPS_FIELD_W-1:0] rps_field_t;

  // Member order matches selection slots 12 down to 3.
  typedef struct packed {
    rps_field_t pwm_fault_pin_field;
    rps_field_t spi2_select_pin_field;
    rps_field_t spi2_clock_pin_field;
    rps_field_t spi2_data_in_pin_field;
    rps_field_t serial2_clock_pin_field;
    rps_field_t serial2_receive_pin_field;
    rps_field_t timer_c_gate_pin_field;
    rps_field_t timer_a_gate_pin_field;
    rps_field_t capture2_pin_field;
    rps_field_t capture1_pin_field;
  } rps_in_sel_s;

  // Member order matches selection slots 2 down to 0.
  typedef struct packed {
    rps_field_t pin2_function_field;
    rps_field_t pin1_function_field;
    rps_field_t pin0_function_field;
  } rps_out_sel_s;

  typedef enum logic [2:0] {
    rps_unl_idle = 3'h1,
    rps_unl_key1 = 3'h2,
    rps_unl_armed = 3'h4
  } rps_unlock_e;

  typedef struct packed {
    logic [`RPS_NUM_SEL-1:0][`RPS_FIELD_W-1:0] sel;
    logic lock;
    rps_unlock_e unlock;
    logic ready;
    logic slverr;
    logic [31:0] rdata;
    logic [1:0] one_way_sync;
    logic fresh;
  } rps_state_s;

endpackage : rps_pkg

// ==== verilog/rps_pin_select.sv ====
// Design decision made here: the APB slave port.
`timescale 1ns/10ps
`include "rps_consts.svh"

// Contract
// - Each input select register holds in bits 4..0 the remappable pin number for its input.
// - Bits 7..5 of every mapping register ignore writes and read as zero.
// - Selection fields take writes only while the lock is clear; locked values stay readable.
// - Reset sets input select fields to all ones and output select fields to zero.
// - Output select registers hold a five-bit function code for remappable pins 0, 1, 2.
// - Capture inputs one and two each have their own input select register.
// - Timer A gate and timer C gate inputs each have an input select register.
// - The second serial port receive and clock inputs each have an input select register.
// - The second SPI data, clock and select inputs each have an input select register.
// - The PWM fault input has its own input select register.
// - The lock is bit 0 of the lock control register, resets to zero, one protects.
// - With the one-way option set, a set lock cannot be cleared until reset.
module rps_pin_select (
  input wire logic i_clk_sys,
  input wire logic i_reset,
  input wire logic i_psel,
  input wire logic i_penable,
  input wire logic i_pwrite,
  input wire logic [13:0] i_paddr,
  input wire logic [31:0] i_pwdata,
  input wire logic i_one_way_lock_option,
  output logic [31:0] o_prdata,
  output logic o_pready,
  output logic o_pslverr,
  output logic o_mapping_write_lock,
  output rps_pkg::rps_in_sel_s o_input_sel,
  output rps_pkg::rps_out_sel_s o_output_sel
);

  localparam logic [`RPS_NUM_SEL-1:0][`RPS_FIELD_W-1:0] SEL_RST =
    {{(`RPS_NUM_SEL-`RPS_NUM_OUT){`RPS_IN_RESET}}, {`RPS_NUM_OUT{`RPS_OUT_RESET}}};

  rps_pkg::rps_state_s st_reg;
  rps_pkg::rps_state_s st_next;
  rps_pkg::rps_slot_t slot_cur;
  logic wr_acc;

  // Word-aligned addresses only; a misaligned address is treated as unmapped.
  function automatic rps_pkg::rps_slot_t rps_decode(input logic [13:0] addr);
    rps_pkg::rps_slot_t slot;
    slot = `RPS_SLOT_NONE;
    if (addr[1:0] == 2'h0) begin
      case (addr[13:2])
        `RPS_IDX_PIN0_OUT: slot = `RPS_SLOT_PIN0;
        `RPS_IDX_PIN1_OUT: slot = `RPS_SLOT_PIN1;
        `RPS_IDX_PIN2_OUT: slot = `RPS_SLOT_PIN2;
        `RPS_IDX_CAPTURE1: slot = `RPS_SLOT_CAPTURE1;
        `RPS_IDX_CAPTURE2: slot = `RPS_SLOT_CAPTURE2;
        `RPS_IDX_TIMER_A_GATE: slot = `RPS_SLOT_TIMER_A;
        `RPS_IDX_TIMER_C_GATE: slot = `RPS_SLOT_TIMER_C;
        `RPS_IDX_SERIAL2_RX: slot = `RPS_SLOT_SER_RX;
        `RPS_IDX_SERIAL2_CLK: slot = `RPS_SLOT_SER_CLK;
        `RPS_IDX_SPI2_DATA: slot = `RPS_SLOT_SPI_DATA;
        `RPS_IDX_SPI2_CLK: slot = `RPS_SLOT_SPI_CLK;
        `RPS_IDX_SPI2_SEL: slot = `RPS_SLOT_SPI_SEL;
        `RPS_IDX_PWM_FAULT: slot = `RPS_SLOT_FAULT;
        `RPS_IDX_LOCK_CTRL: slot = `RPS_SLOT_LOCK;
        `RPS_IDX_UNLOCK: slot = `RPS_SLOT_UNLOCK;
        default: slot = `RPS_SLOT_NONE;
      endcase
    end
    return slot;
  endfunction : rps_decode

  assign slot_cur = rps_decode(i_paddr);
  // The write takes effect at the edge where the master samples pready high.
  assign wr_acc = i_psel && i_penable && st_reg.ready && i_pwrite;

  always_comb begin
    st_next = st_reg;
    st_next.fresh = 1'b0;
    // The option strap may come from outside this clock domain, so it is synchronised.
    st_next.one_way_sync = {st_reg.one_way_sync[0], i_one_way_lock_option};
    st_next.ready = 1'b0;
    st_next.slverr = 1'b0;

    // Setup phase: decode, prepare the read word and raise pready for the access phase.
    if (i_psel && !i_penable) begin
      st_next.ready = 1'b1;
      st_next.slverr = (slot_cur == `RPS_SLOT_NONE);
      st_next.rdata = 32'h0000_0000;
      if (slot_cur < 4'(`RPS_NUM_SEL)) begin
        st_next.rdata[`RPS_FIELD_W-1:0] = st_reg.sel[slot_cur];
      end else if (slot_cur == `RPS_SLOT_LOCK) begin
        st_next.rdata[`RPS_LOCK_BIT] = st_reg.lock;
      end
      // Upper bits stay zero; the unlock register reads as zero too.
    end

    if (wr_acc) begin
      // Only bits 4..0 are stored, so bits 7..5 can never be written.
      if (slot_cur < 4'(`RPS_NUM_SEL) && !st_reg.lock) begin
        st_next.sel[slot_cur] = i_pwdata[`RPS_FIELD_W-1:0];
      end

      // A lock change is taken only right after the two key bytes.
      if (slot_cur == `RPS_SLOT_LOCK && st_reg.unlock == rps_pkg::rps_unl_armed) begin
        if (!(st_reg.one_way_sync[1] && st_reg.lock)) begin
          st_next.lock = i_pwdata[`RPS_LOCK_BIT];
        end
      end

      // Any write other than the next key byte or the first key byte breaks the sequence.
      st_next.unlock = rps_pkg::rps_unl_idle;
      if (slot_cur == `RPS_SLOT_UNLOCK) begin
        case (st_reg.unlock)
          rps_pkg::rps_unl_idle: begin
            if (i_pwdata[7:0] == `RPS_UNLOCK_KEY1) begin
              st_next.unlock = rps_pkg::rps_unl_key1;
            end
          end
          rps_pkg::rps_unl_key1: begin
            if (i_pwdata[7:0] == `RPS_UNLOCK_KEY2) begin
              st_next.unlock = rps_pkg::rps_unl_armed;
            end else if (i_pwdata[7:0] == `RPS_UNLOCK_KEY1) begin
              st_next.unlock = rps_pkg::rps_unl_key1;
            end
          end
          rps_pkg::rps_unl_armed: begin
            if (i_pwdata[7:0] == `RPS_UNLOCK_KEY1) begin
              st_next.unlock = rps_pkg::rps_unl_key1;
            end
          end
          default: begin
            st_next.unlock = rps_pkg::rps_unl_idle;
          end
        endcase
      end
    end
  end

  always_ff @(posedge i_clk_sys or posedge i_reset) begin
    if (i_reset) begin
      st_reg <= '{sel: SEL_RST,
                  lock: `RPS_LOCK_RESET,
                  unlock: rps_pkg::rps_unl_idle,
                  ready: 1'b0,
                  slverr: 1'b0,
                  rdata: 32'h0000_0000,
                  one_way_sync: 2'h0,
                  fresh: 1'b1};
    end else begin
      st_reg <= st_next;
    end
  end

  // All outputs are plain taps of the state register.
  assign o_prdata = st_reg.rdata;
  assign o_pready = st_reg.ready;
  assign o_pslverr = st_reg.slverr;
  assign o_mapping_write_lock = st_reg.lock;
  assign o_input_sel = st_reg.sel[`RPS_NUM_SEL-1:`RPS_NUM_OUT];
  assign o_output_sel = st_reg.sel[`RPS_NUM_OUT-1:0];

  default clocking cb @(posedge i_clk_sys);
  endclocking
  default disable iff (i_reset);

  chk_sel_write_capt: assert property (
    wr_acc && slot_cur == `RPS_SLOT_CAPTURE1 && !o_mapping_write_lock
    |=> o_input_sel.capture1_pin_field == $past(i_pwdata[`RPS_FIELD_W-1:0]))
    else $error("capture one select did not take the written pin number");

  chk_upper_zero: assert property (
    i_psel && i_penable && o_pready |-> o_prdata[31:`RPS_FIELD_W] == 27'h0)
    else $error("read data above the selection field is not zero");

  chk_locked_hold: assert property (
    o_mapping_write_lock |=> $stable(o_input_sel) && $stable(o_output_sel))
    else $error("a selection field changed while the lock was set");

  chk_reset_values: assert property (
    st_reg.fresh |-> o_input_sel == {(`RPS_NUM_SEL-`RPS_NUM_OUT){`RPS_IN_RESET}}
      && o_output_sel == {`RPS_NUM_OUT{`RPS_OUT_RESET}} && !o_mapping_write_lock)
    else $error("selection registers left reset with wrong values");

  chk_pin_func_write: assert property (
    wr_acc && slot_cur == `RPS_SLOT_PIN2 && !o_mapping_write_lock
    |=> o_output_sel.pin2_function_field == $past(i_pwdata[`RPS_FIELD_W-1:0])
      && $stable(o_output_sel.pin1_function_field))
    else $error("pin two function code not stored or pin one disturbed");

  chk_capture_split: assert property (
    wr_acc && slot_cur == `RPS_SLOT_CAPTURE2
    |=> $stable(o_input_sel.capture1_pin_field))
    else $error("a capture two write changed the capture one select");

  chk_gate_route: assert property (
    wr_acc && slot_cur == `RPS_SLOT_TIMER_C && !o_mapping_write_lock
    |=> o_input_sel.timer_c_gate_pin_field == $past(i_pwdata[`RPS_FIELD_W-1:0])
      && $stable(o_input_sel.timer_a_gate_pin_field))
    else $error("timer c gate select wrong or timer a gate disturbed");

  chk_serial_route: assert property (
    wr_acc && slot_cur == `RPS_SLOT_SER_CLK && !o_mapping_write_lock
    |=> o_input_sel.serial2_clock_pin_field == $past(i_pwdata[`RPS_FIELD_W-1:0])
      && $stable(o_input_sel.serial2_receive_pin_field))
    else $error("serial clock select wrong or receive select disturbed");

  chk_spi_route: assert property (
    wr_acc && slot_cur == `RPS_SLOT_SPI_SEL && !o_mapping_write_lock
    |=> o_input_sel.spi2_select_pin_field == $past(i_pwdata[`RPS_FIELD_W-1:0])
      && $stable(o_input_sel.spi2_clock_pin_field))
    else $error("spi select input not routed as written");

  chk_fault_route: assert property (
    wr_acc && slot_cur == `RPS_SLOT_FAULT && !o_mapping_write_lock
    |=> o_input_sel.pwm_fault_pin_field == $past(i_pwdata[`RPS_FIELD_W-1:0]))
    else $error("pwm fault select not stored");

  chk_lock_set: assert property (
    wr_acc && slot_cur == `RPS_SLOT_LOCK && st_reg.unlock == rps_pkg::rps_unl_armed
      && i_pwdata[`RPS_LOCK_BIT]
    |=> o_mapping_write_lock ##1 o_mapping_write_lock || $past(wr_acc))
    else $error("lock did not set after an armed lock write");

  chk_one_way: assert property (
    st_reg.one_way_sync[1] && o_mapping_write_lock |=> o_mapping_write_lock)
    else $error("lock cleared while the one-way option was set");

  chk_unlock_needed: assert property (
    wr_acc && slot_cur == `RPS_SLOT_LOCK && st_reg.unlock != rps_pkg::rps_unl_armed
    |=> $stable(o_mapping_write_lock))
    else $error("lock changed without the unlock sequence");

  chk_answer_time: assert property (
    i_psel && !i_penable ##1 i_psel && i_penable |-> o_pready)
    else $error("pready not high in the first access cycle");

  chk_capture2_write: assert property (
    wr_acc && slot_cur == `RPS_SLOT_CAPTURE2 && !o_mapping_write_lock
    |=> o_input_sel.capture2_pin_field == $past(i_pwdata[`RPS_FIELD_W-1:0]))
    else $error("capture two select did not take the written pin number");

  chk_timer_a_write: assert property (
    wr_acc && slot_cur == `RPS_SLOT_TIMER_A && !o_mapping_write_lock
    |=> o_input_sel.timer_a_gate_pin_field == $past(i_pwdata[`RPS_FIELD_W-1:0])
      && $stable(o_input_sel.timer_c_gate_pin_field))
    else $error("timer a gate select wrong or timer c gate disturbed");

  chk_serial_rx_write: assert property (
    wr_acc && slot_cur == `RPS_SLOT_SER_RX && !o_mapping_write_lock
    |=> o_input_sel.serial2_receive_pin_field == $past(i_pwdata[`RPS_FIELD_W-1:0])
      && $stable(o_input_sel.serial2_clock_pin_field))
    else $error("serial receive select wrong or clock select disturbed");

  chk_spi_data_write: assert property (
    wr_acc && slot_cur == `RPS_SLOT_SPI_DATA && !o_mapping_write_lock
    |=> o_input_sel.spi2_data_in_pin_field == $past(i_pwdata[`RPS_FIELD_W-1:0])
      && $stable(o_input_sel.spi2_select_pin_field))
    else $error("spi data select wrong or spi select input disturbed");

  chk_spi_clock_write: assert property (
    wr_acc && slot_cur == `RPS_SLOT_SPI_CLK && !o_mapping_write_lock
    |=> o_input_sel.spi2_clock_pin_field == $past(i_pwdata[`RPS_FIELD_W-1:0]))
    else $error("spi clock select not stored");

  chk_pin0_func_write: assert property (
    wr_acc && slot_cur == `RPS_SLOT_PIN0 && !o_mapping_write_lock
    |=> o_output_sel.pin0_function_field == $past(i_pwdata[`RPS_FIELD_W-1:0])
      && $stable(o_output_sel.pin2_function_field))
    else $error("pin zero function code not stored or pin two disturbed");

  chk_pin1_func_write: assert property (
    wr_acc && slot_cur == `RPS_SLOT_PIN1 && !o_mapping_write_lock
    |=> o_output_sel.pin1_function_field == $past(i_pwdata[`RPS_FIELD_W-1:0])
      && $stable(o_output_sel.pin0_function_field))
    else $error("pin one function code not stored or pin zero disturbed");

  chk_read_field: assert property (
    i_psel && !i_penable && slot_cur < 4'(`RPS_NUM_SEL)
    |=> o_prdata == {27'h0, $past(st_reg.sel[slot_cur])})
    else $error("read data does not match the stored selection field");

  chk_locked_readable: assert property (
    o_mapping_write_lock && i_psel && !i_penable && slot_cur < 4'(`RPS_NUM_SEL)
    |=> o_prdata[`RPS_FIELD_W-1:0] == $past(st_reg.sel[slot_cur])
      && !o_pslverr)
    else $error("a locked selection register did not read back its value");

  chk_lock_read: assert property (
    i_psel && !i_penable && slot_cur == `RPS_SLOT_LOCK
    |=> o_prdata == {31'h0, $past(o_mapping_write_lock)})
    else $error("lock control read does not show the lock in bit zero");

  chk_locked_ignore: assert property (
    o_mapping_write_lock && wr_acc && slot_cur < 4'(`RPS_NUM_SEL)
    |=> $stable(o_input_sel) && $stable(o_output_sel) && o_mapping_write_lock)
    else $error("a write to a locked selection register took effect");

  chk_lock_clear: assert property (
    wr_acc && slot_cur == `RPS_SLOT_LOCK && st_reg.unlock == rps_pkg::rps_unl_armed
      && !i_pwdata[`RPS_LOCK_BIT] && !st_reg.one_way_sync[1]
    |=> !o_mapping_write_lock)
    else $error("lock did not clear after an armed lock write");

  chk_one_way_refuse: assert property (
    wr_acc && slot_cur == `RPS_SLOT_LOCK && st_reg.one_way_sync[1]
      && o_mapping_write_lock && !i_pwdata[`RPS_LOCK_BIT]
    |=> o_mapping_write_lock)
    else $error("a lock clear was taken with the one-way option set");

  chk_key_first: assert property (
    wr_acc && slot_cur == `RPS_SLOT_UNLOCK && i_pwdata[7:0] == `RPS_UNLOCK_KEY1
    |=> st_reg.unlock == rps_pkg::rps_unl_key1)
    else $error("first key byte did not start the unlock sequence");

  chk_key_second: assert property (
    wr_acc && slot_cur == `RPS_SLOT_UNLOCK && st_reg.unlock == rps_pkg::rps_unl_key1
      && i_pwdata[7:0] == `RPS_UNLOCK_KEY2 |=> st_reg.unlock == rps_pkg::rps_unl_armed)
    else $error("second key byte did not arm the lock write");

  chk_key_break: assert property (
    wr_acc && slot_cur != `RPS_SLOT_UNLOCK
    |=> st_reg.unlock == rps_pkg::rps_unl_idle)
    else $error("unlock sequence survived a write elsewhere");

  chk_unmapped_error:
    assert property (i_psel && !i_penable && slot_cur == `RPS_SLOT_NONE |=> o_pslverr && o_prdata == 32'h0)
    else $error("unmapped access did not answer with an error and zero data");

  chk_mapped_okay:
    assert property (i_psel && !i_penable && slot_cur != `RPS_SLOT_NONE |=> o_pready && !o_pslverr)
    else $error("mapped access answered with an error");

  chk_ready_pulse: assert property (
    o_pready |=> !o_pready)
    else $error("pready stood for more than one cycle");

  chk_ready_cause: assert property (
    o_pready |-> $past(i_psel && !i_penable))
    else $error("pready rose without a setup cycle before it");

  chk_unmapped_no_write: assert property (
    wr_acc && slot_cur == `RPS_SLOT_NONE
    |=> $stable(o_input_sel) && $stable(o_output_sel)
      && $stable(o_mapping_write_lock))
    else $error("a write to an unmapped address changed a register");

  chk_option_sync: assert property (
    1'b1 |=> st_reg.one_way_sync[1] == $past(st_reg.one_way_sync[0]))
    else $error("one-way option skipped a synchroniser stage");

endmodule : rps_pin_select

// ==== verif/tb.sv ====
`timescale 1ns/10ps
`include "rps_consts.svh"

module tb;
  localparam logic [11:0] IDX [13] = '{`RPS_IDX_CAPTURE1, `RPS_IDX_CAPTURE2, `RPS_IDX_TIMER_A_GATE,
    `RPS_IDX_TIMER_C_GATE, `RPS_IDX_SERIAL2_RX, `RPS_IDX_SERIAL2_CLK, `RPS_IDX_SPI2_DATA,
    `RPS_IDX_SPI2_CLK, `RPS_IDX_SPI2_SEL, `RPS_IDX_PWM_FAULT, `RPS_IDX_PIN0_OUT,
    `RPS_IDX_PIN1_OUT, `RPS_IDX_PIN2_OUT};
  logic clk_sys = 1'b0;
  logic reset = 1'b1;
  logic psel = 1'b0;
  logic penable = 1'b0;
  logic pwrite = 1'b0;
  logic [13:0] paddr = 14'h0000;
  logic [31:0] pwdata = 32'h00000000;
  logic one_way = 1'b0;
  logic [31:0] prdata;
  logic pready;
  logic pslverr;
  logic lock;
  logic [49:0] in_vec;
  logic [14:0] out_vec;
  logic [31:0] rd;
  logic err;
  int errors = 0;
  int comparisons = 0;
  int cycles = 0;

  rps_pin_select u_dut (
    .i_clk_sys(clk_sys),
    .i_reset(reset),
    .i_psel(psel),
    .i_penable(penable),
    .i_pwrite(pwrite),
    .i_paddr(paddr),
    .i_pwdata(pwdata),
    .i_one_way_lock_option(one_way),
    .o_prdata(prdata),
    .o_pready(pready),
    .o_pslverr(pslverr),
    .o_mapping_write_lock(lock),
    .o_input_sel(in_vec),
    .o_output_sel(out_vec)
  );

  always #12.5 clk_sys = ~clk_sys;

  task automatic finish_test();
    if (errors == 0 && comparisons > 0) begin
      $display("Simulation passed");
    end else begin
      $display("Simulation failed");
    end
    $finish;
  endtask : finish_test

  // The run is a few hundred cycles; the ceiling only cuts a hung handshake short.
  always @(posedge clk_sys) begin
    cycles <= cycles + 1;
    if (cycles == 5000) begin
      errors = errors + 1;
      finish_test();
    end
  end

  task automatic chk(input string what, input logic [63:0] exp, input logic [63:0] got);
    comparisons = comparisons + 1;
    if (got !== exp) begin
      errors = errors + 1;
      $display("MISMATCH %s expected %h seen %h", what, exp, got);
    end
  endtask : chk

  task automatic apb(input logic wr, input logic [13:0] a, input logic [31:0] d, output logic [31:0] r,
                     output logic e);
    @(posedge clk_sys);
    psel <= 1'b1;
    penable <= 1'b0;
    pwrite <= wr;
    paddr <= a;
    pwdata <= d;
    @(posedge clk_sys);
    penable <= 1'b1;
    // Only the bench timeout ends a wait for pready.
    do begin
      @(posedge clk_sys);
    end while (pready !== 1'b1);
    r = prdata;
    e = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
  endtask : apb

  task automatic wr_reg(input logic [11:0] idx, input logic [31:0] d);
    apb(1'b1, {idx, 2'b00}, d, rd, err);
  endtask : wr_reg

  task automatic rd_reg(input logic [11:0] idx, input logic [31:0] exp);
    apb(1'b0, {idx, 2'b00}, 32'h00000000, rd, err);
    chk("read data", {32'h00000000, exp}, {32'h00000000, rd});
    chk("read error", 64'h0, {63'h0, err});
  endtask : rd_reg

  task automatic set_lock(input logic v);
    wr_reg(`RPS_IDX_UNLOCK, 32'(`RPS_UNLOCK_KEY1));
    wr_reg(`RPS_IDX_UNLOCK, 32'(`RPS_UNLOCK_KEY2));
    wr_reg(`RPS_IDX_LOCK_CTRL, {31'h0, v});
    @(posedge clk_sys);
  endtask : set_lock

  task automatic do_reset();
    reset <= 1'b1;
    repeat (4) @(posedge clk_sys);
    reset <= 1'b0;
  endtask : do_reset

  // Every mapping register must come back from reset to its reset value.
  task automatic check_defaults();
    for (int k = 0; k < 13; k++) begin
      rd_reg(IDX[k], (k < 10) ? 32'h0000001F : 32'h00000000);
    end
    chk("input fields", {14'h0, {10{`RPS_IN_RESET}}}, {14'h0, in_vec});
    chk("output fields", 64'h0, {49'h0, out_vec});
    chk("lock", 64'h0, {63'h0, lock});
  endtask : check_defaults

  initial begin
    do_reset();
    check_defaults();
    for (int k = 0; k < 13; k++) begin
      wr_reg(IDX[k], 32'hFFFFFFE0 | 32'((k * 7 + 3) % 32));
      @(posedge clk_sys);
      rd_reg(IDX[k], 32'((k * 7 + 3) % 32));
      if (k < 10) begin
        chk("input field", 64'((k * 7 + 3) % 32), {59'h0, in_vec[5 * k +: 5]});
      end else begin
        chk("output field", 64'((k * 7 + 3) % 32), {59'h0, out_vec[5 * (k - 10) +: 5]});
      end
    end
    apb(1'b0, 14'h0000, 32'h0, rd, err);
    chk("unmapped error", 64'h1, {63'h0, err});
    apb(1'b0, {`RPS_IDX_PIN0_OUT, 2'b01}, 32'h0, rd, err);
    chk("misaligned error", 64'h1, {63'h0, err});
    // A foreign write between the two key bytes breaks the sequence.
    wr_reg(`RPS_IDX_UNLOCK, 32'(`RPS_UNLOCK_KEY1));
    wr_reg(IDX[0], 32'h00000003);
    wr_reg(`RPS_IDX_UNLOCK, 32'(`RPS_UNLOCK_KEY2));
    wr_reg(`RPS_IDX_LOCK_CTRL, 32'h00000001);
    @(posedge clk_sys);
    chk("lock after broken keys", 64'h0, {63'h0, lock});
    set_lock(1'b1);
    chk("lock set", 64'h1, {63'h0, lock});
    rd_reg(`RPS_IDX_LOCK_CTRL, 32'h00000001);
    for (int k = 0; k < 13; k += 4) begin
      wr_reg(IDX[k], 32'h0000000A);
      rd_reg(IDX[k], (k == 0) ? 32'h00000003 : 32'((k * 7 + 3) % 32));
    end
    wr_reg(`RPS_IDX_LOCK_CTRL, 32'h00000000);
    @(posedge clk_sys);
    chk("lock without keys", 64'h1, {63'h0, lock});
    set_lock(1'b0);
    chk("lock cleared", 64'h0, {63'h0, lock});
    wr_reg(IDX[12], 32'h00000015);
    rd_reg(IDX[12], 32'h00000015);
    one_way <= 1'b1;
    repeat (3) @(posedge clk_sys);
    set_lock(1'b1);
    set_lock(1'b0);
    chk("one way lock", 64'h1, {63'h0, lock});
    do_reset();
    check_defaults();
    finish_test();
  end
endmodule : tb
